//--- rtl/mcr_pkg.sv
// Constants and types for the monitor conversion-rate and result block
`default_nettype none
package mcr_pkg;
	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [7:0] MCR_BASE_RATE_OFS = 8'h07;
	localparam logic [7:0] MCR_CHAN_DIS_OFS = 8'h08;
	localparam logic [7:0] MCR_RATE_SEL_OFS = 8'h09;
	localparam logic [7:0] MCR_RES0_OFS = 8'h20;
	localparam logic [7:0] MCR_RES1_OFS = 8'h21;
	localparam logic [7:0] MCR_RES2_OFS = 8'h22;
	localparam logic [7:0] MCR_RES3_OFS = 8'h23;
	localparam int MCR_RES_LSB = 6;
	localparam int MCR_RES_W = 10;
	localparam int MCR_SEL_W = 3;
	localparam int MCR_NCH = 4;
	localparam logic [2:0] MCR_SEL_RST = 3'h0;
	localparam logic MCR_BASE_RST = 1'b0;
	localparam logic [7:0] MCR_DIS_RST = 8'h00;
	localparam logic [9:0] MCR_RES_RST = 10'h000;
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int MCR_CLK_MHZ = 50;
	localparam int MCR_T1_US = 1200;
	localparam int MCR_T2_US = 4800;
	localparam int MCR_T3_US = 9600;
	localparam int MCR_T4_US = 38000;
	localparam int MCR_T5_US = 77000;
	localparam int MCR_T6_US = 154000;
	localparam int MCR_T7_US = 614000;
	localparam int MCR_TSLOW_US = 728000;
	localparam int MCR_C1 = MCR_T1_US * MCR_CLK_MHZ;
	localparam int MCR_C2 = MCR_T2_US * MCR_CLK_MHZ;
	localparam int MCR_C3 = MCR_T3_US * MCR_CLK_MHZ;
	localparam int MCR_C4 = MCR_T4_US * MCR_CLK_MHZ;
	localparam int MCR_C5 = MCR_T5_US * MCR_CLK_MHZ;
	localparam int MCR_C6 = MCR_T6_US * MCR_CLK_MHZ;
	localparam int MCR_C7 = MCR_T7_US * MCR_CLK_MHZ;
	localparam int MCR_CSLOW = MCR_TSLOW_US * MCR_CLK_MHZ;
	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef struct packed {
		logic [1:0] chan;
		logic [9:0] value;
	} mcr_result_type;
	typedef enum logic [1:0] {MCR_IDLE, MCR_START, MCR_WAIT} mcr_state_type;
endpackage : mcr_pkg
`default_nettype wire

//--- rtl/mcr_top.sv
// Conversion loop pacing, rate registers and analog result registers
`default_nettype none
module mcr_top
	import mcr_pkg::*;
#(
	parameter int unsigned PER_C1 = MCR_C1,
	parameter int unsigned PER_C2 = MCR_C2,
	parameter int unsigned PER_C3 = MCR_C3,
	parameter int unsigned PER_C4 = MCR_C4,
	parameter int unsigned PER_C5 = MCR_C5,
	parameter int unsigned PER_C6 = MCR_C6,
	parameter int unsigned PER_C7 = MCR_C7,
	parameter int unsigned PER_SLOW = MCR_CSLOW
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	output logic reg_rvalid,
	output logic conv_start,
	output logic [1:0] conv_chan,
	input wire logic conv_done,
	input wire mcr_result_type conv_result,
	output logic loop_busy
);
	// ----------------------------------------
	// Control registers
	// ----------------------------------------
	logic base_rate_q;
	logic [7:0] chan_dis_q;
	logic [2:0] rate_sel_q;
	logic [9:0] res_q [MCR_NCH];

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			base_rate_q <= MCR_BASE_RST;
			chan_dis_q <= MCR_DIS_RST;
			rate_sel_q <= MCR_SEL_RST;
		end else if (reg_wr) begin
			if (reg_addr == MCR_BASE_RATE_OFS)
				base_rate_q <= reg_wdata[0];
			if (reg_addr == MCR_CHAN_DIS_OFS)
				chan_dis_q <= reg_wdata;
			if (reg_addr == MCR_RATE_SEL_OFS)
				rate_sel_q <= reg_wdata[2:0];
		end
	end

	// ----------------------------------------
	// Loop period selection
	// ----------------------------------------
	function automatic int unsigned period_of(input logic [2:0] sel);
		unique case (sel)
			3'h1: period_of = PER_C1;
			3'h2: period_of = PER_C2;
			3'h3: period_of = PER_C3;
			3'h4: period_of = PER_C4;
			3'h5: period_of = PER_C5;
			3'h6: period_of = PER_C6;
			3'h7: period_of = PER_C7;
			3'h0: period_of = PER_SLOW;
		endcase
	endfunction : period_of

	logic continuous;
	int unsigned period;
	assign continuous = (rate_sel_q == 3'h0) && base_rate_q;
	assign period = period_of(rate_sel_q);

	// ----------------------------------------
	// Loop timer and sequencer
	// ----------------------------------------
	mcr_state_type state_q;
	logic [31:0] tmr_q;
	logic first_q;
	logic [1:0] ch_q;
	logic loop_go;
	logic ch_skip;

	assign loop_go = (state_q == MCR_IDLE) &&
		(first_q || continuous || (tmr_q >= period - 32'h1));
	assign ch_skip = chan_dis_q[ch_q];
	assign loop_busy = (state_q != MCR_IDLE);

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			tmr_q <= 32'h0;
		else if (loop_go)
			tmr_q <= 32'h0;
		else if (tmr_q != 32'hFFFFFFFF)
			tmr_q <= tmr_q + 32'h1;
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_q <= MCR_IDLE;
			first_q <= 1'b1;
			ch_q <= 2'h0;
			conv_start <= 1'b0;
			conv_chan <= 2'h0;
		end else begin
			conv_start <= 1'b0;
			unique case (state_q)
				MCR_IDLE: begin
					if (loop_go) begin
						first_q <= 1'b0;
						ch_q <= 2'h0;
						state_q <= MCR_START;
					end
				end
				MCR_START: begin
					if (ch_skip) begin
						ch_q <= ch_q + 2'h1;
						if (ch_q == 2'h3)
							state_q <= MCR_IDLE;
					end else begin
						conv_start <= 1'b1;
						conv_chan <= ch_q;
						state_q <= MCR_WAIT;
					end
				end
				MCR_WAIT: begin
					if (conv_done) begin
						ch_q <= ch_q + 2'h1;
						state_q <= (ch_q == 2'h3) ? MCR_IDLE : MCR_START;
					end
				end
			endcase
		end
	end

	// ----------------------------------------
	// Result registers
	// ----------------------------------------
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			for (int i = 0; i < MCR_NCH; i++)
				res_q[i] <= MCR_RES_RST;
		end else if (state_q == MCR_WAIT && conv_done) begin
			res_q[ch_q] <= conv_result.value;
		end
	end

	// ----------------------------------------
	// Register read port
	// ----------------------------------------
	function automatic logic [15:0] res_word(input logic [1:0] ch);
		res_word = chan_dis_q[ch] ? 16'h0000 : {res_q[ch], 6'h00};
	endfunction : res_word

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			reg_rdata <= 16'h0000;
			reg_rvalid <= 1'b0;
		end else begin
			reg_rvalid <= reg_rd;
			if (reg_rd) begin
				unique case (reg_addr)
					MCR_BASE_RATE_OFS: reg_rdata <= {15'h0000, base_rate_q};
					MCR_CHAN_DIS_OFS: reg_rdata <= {8'h00, chan_dis_q};
					MCR_RATE_SEL_OFS: reg_rdata <= {13'h0000, rate_sel_q};
					MCR_RES0_OFS: reg_rdata <= res_word(2'h0);
					MCR_RES1_OFS: reg_rdata <= res_word(2'h1);
					MCR_RES2_OFS: reg_rdata <= res_word(2'h2);
					MCR_RES3_OFS: reg_rdata <= res_word(2'h3);
					default: reg_rdata <= 16'h0000;
				endcase
			end
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	sel_zero_follows_a: assert property ((rate_sel_q == 3'h0) |-> (continuous == base_rate_q))
		else $error("basic rate bit not followed");
	sel_override_a: assert property ((rate_sel_q != 3'h0) |-> (!continuous && period != PER_SLOW))
		else $error("selector did not override basic rate bit");
	rate_low_codes_a: assert property ((rate_sel_q == 3'h3) |-> (period == PER_C3))
		else $error("code three period wrong");
	rate_high_codes_a: assert property ((rate_sel_q == 3'h7) |-> (period == PER_C7))
		else $error("code seven period wrong");
	rate_code_one_a: assert property ((rate_sel_q == 3'h1) |-> (period == PER_C1))
		else $error("code one period wrong");
	rate_code_four_a: assert property ((rate_sel_q == 3'h4) |-> (period == PER_C4))
		else $error("code four period wrong");
	rate_code_six_a: assert property ((rate_sel_q == 3'h6) |-> (period == PER_C6))
		else $error("code six period wrong");
	result_low_zero_a: assert property (reg_rvalid
		&& $past(reg_addr[7:2]) == MCR_RES0_OFS[7:2] |-> reg_rdata[5:0] == 6'h00)
		else $error("result low bits not zero");
	result_read_only_a: assert property (reg_wr && reg_addr == MCR_RES1_OFS
		&& !(state_q == MCR_WAIT && ch_q == 2'h1) |=> $stable(res_q[1]))
		else $error("host write changed a result");
	slow_period_a: assert property ($rose(loop_busy) && rate_sel_q == 3'h0
		&& !base_rate_q && $past(rate_sel_q) == 3'h0 && !$past(base_rate_q)
		&& !$past(first_q) |-> $past(tmr_q) >= PER_SLOW - 1)
		else $error("slow loop started early");
	slow_go_a: assert property (state_q == MCR_IDLE && rate_sel_q == 3'h0
		&& !base_rate_q && tmr_q >= PER_SLOW - 1 |=> loop_busy)
		else $error("slow loop started late");
	continuous_go_a: assert property ((state_q == MCR_IDLE && continuous) |=> loop_busy)
		else $error("continuous loop did not restart");
	skip_disabled_a: assert property (conv_start |-> !$past(chan_dis_q[ch_q]))
		else $error("disabled channel converted");
	disabled_reads_zero_a: assert property (reg_rvalid
		&& $past(reg_addr) == MCR_RES2_OFS && $past(chan_dis_q[2]) |-> reg_rdata == 16'h0000)
		else $error("disabled channel read not zero");
	result_on_done_a: assert property ($changed(res_q[1])
		|-> $past(conv_done && ch_q == 2'h1 && state_q == MCR_WAIT))
		else $error("result changed without completion");

	loop_cover_c: cover property ($rose(loop_busy) ##[1:20] $fell(loop_busy));
	skip_cover_c: cover property (state_q == MCR_START && ch_skip);
	cont_cover_c: cover property (continuous && $fell(loop_busy) ##1 loop_busy);
	disabled_read_c: cover property (reg_rvalid && $past(reg_addr) == MCR_RES2_OFS
		&& $past(chan_dis_q[2]));
endmodule : mcr_top
`default_nettype wire

//--- tb/mcr_conv_model.sv
// Behavioural converter answering the block's conversion requests
`default_nettype none
module mcr_conv_model
	import mcr_pkg::*;
(
	input wire logic clk,
	input wire logic conv_start,
	input wire logic [1:0] conv_chan,
	input wire logic [7:0] seed,
	input wire logic [31:0] dly,
	output logic conv_done,
	output mcr_result_type conv_result
);
	timeunit 1ns;
	timeprecision 1ns;
	// Result is valid only with the done pulse; inverted afterwards
	initial begin
		conv_done = 1'b0;
		conv_result = '0;
		forever begin
			@(negedge clk);
			if (conv_start) begin
				repeat (dly) @(posedge clk);
				conv_done <= 1'b1;
				conv_result <= '{chan: conv_chan, value: {seed, conv_chan}};
				@(posedge clk);
				conv_done <= 1'b0;
				conv_result <= ~conv_result;
			end
		end
	end
endmodule : mcr_conv_model
`default_nettype wire

//--- tb/testbench.sv
// Self-checking bench for the conversion-rate and result block
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin error_cnt++; \
$display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module testbench
	import mcr_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ns;
	localparam int unsigned P[8] = '{150, 60, 70, 80, 90, 100, 110, 120};
	logic clk, resetn, reg_wr, reg_rd, reg_rvalid, conv_start, conv_done, loop_busy;
	logic [7:0] reg_addr, reg_wdata, seed;
	logic [15:0] reg_rdata;
	logic [1:0] conv_chan;
	mcr_result_type conv_result;
	int error_cnt = 0, checked = 0, cyc = 0, dly = 40, ch2_cnt = 0;
	mcr_top #(.PER_C1(P[1]), .PER_C2(P[2]), .PER_C3(P[3]), .PER_C4(P[4]), .PER_C5(P[5]),
		.PER_C6(P[6]), .PER_C7(P[7]), .PER_SLOW(P[0])) dut (.clk(clk), .resetn(resetn),
		.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .conv_start(conv_start),
		.conv_chan(conv_chan), .conv_done(conv_done), .conv_result(conv_result),
		.loop_busy(loop_busy));
	mcr_conv_model conv (.clk(clk), .conv_start(conv_start), .conv_chan(conv_chan),
		.seed(seed), .dly(dly), .conv_done(conv_done), .conv_result(conv_result));
	// ----------------------------------------
	// Bus and timing helpers
	// ----------------------------------------
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		@(posedge clk);
	endtask : wr
	task automatic rdchk(input logic [7:0] a, input logic [15:0] e);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		`CHK({reg_rvalid, reg_rdata}, {1'b1, e})
		@(posedge clk);
	endtask : rdchk
	// Cycles from one loop start to the next, and the idle gap before it
	task automatic per(output int n, output int g);
		@(posedge loop_busy);
		n = 0;
		while (loop_busy === 1'b1) begin
			@(posedge clk);
			#1;
			n++;
		end
		g = n;
		while (loop_busy !== 1'b1) begin
			@(posedge clk);
			#1;
			n++;
		end
		g = n - g;
		@(posedge clk);
	endtask : per
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset();
		rdchk(MCR_RATE_SEL_OFS, 16'h0000);
		for (int c = 0; c < 4; c++) begin
			rdchk(MCR_RES0_OFS + 8'(c), 16'h0000);
		end
	endtask : t_reset
	task automatic t_results();
		int n, g;
		dly = 3;
		seed = 8'hA5;
		per(n, g);
		per(n, g);
		for (int c = 0; c < 4; c++) begin
			rdchk(MCR_RES0_OFS + 8'(c), {8'hA5, 2'(c), 6'h00});
		end
	endtask : t_results
	task automatic t_disable();
		int n, g;
		wr(MCR_CHAN_DIS_OFS, 8'h04);
		seed = 8'h3C;
		per(n, g);
		ch2_cnt = 0;
		per(n, g);
		`CHK(ch2_cnt, 0)
		rdchk(MCR_RES2_OFS, 16'h0000);
		rdchk(MCR_CHAN_DIS_OFS, 16'h0004);
		wr(MCR_RES1_OFS, 8'hFF);
		rdchk(MCR_RES1_OFS, {8'h3C, 2'h1, 6'h00});
	endtask : t_disable
	task automatic t_rates();
		int n, g;
		for (int s = 0; s < 8; s++) begin
			wr(MCR_RATE_SEL_OFS, 8'(s));
			wr(MCR_BASE_RATE_OFS, {7'h00, s != 0});
			rdchk(MCR_RATE_SEL_OFS, 16'(s));
			rdchk(MCR_BASE_RATE_OFS, {15'h0, s != 0});
			per(n, g);
			per(n, g);
			`CHK(n, P[s])
		end
		wr(MCR_RATE_SEL_OFS, 8'h00);
		wr(MCR_BASE_RATE_OFS, 8'h01);
		per(n, g);
		per(n, g);
		`CHK(g <= 2, 1'b1)
	endtask : t_rates
	task automatic print_verdict();
		$display("checks=%0d mismatches=%0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : print_verdict
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (conv_start && conv_chan == 2'h2) begin
			ch2_cnt++;
		end
		if (cyc == 20000) begin
			error_cnt++;
			print_verdict();
		end
	end
	initial begin
		resetn = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		seed = 8'h00;
		repeat (12) @(posedge clk);
		resetn <= 1'b1;
		t_reset();
		t_results();
		t_disable();
		t_rates();
		print_verdict();
	end
endmodule : testbench
`default_nettype wire
